/* logic/mih_pkg.sv */
// package: register offsets, field positions and constants for the interrupt handler
package mih_pkg;
  localparam int NUM_SRC = 22;
  localparam int SRC_W = 5;
  // special function register addresses
  localparam logic [7:0] ADDR_TMR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hA8;
  localparam logic [7:0] ADDR_IRQ_PRI = 8'hB8;
  localparam logic [7:0] ADDR_XIRQ_EN1 = 8'hE6;
  localparam logic [7:0] ADDR_XIRQ_EN2 = 8'hE7;
  localparam logic [7:0] ADDR_EIP1 = 8'hF6;
  localparam logic [7:0] ADDR_EIP2 = 8'hF7;
  localparam logic [7:0] ADDR_ACCUM = 8'hE0;
  localparam logic [7:0] ADDR_OPERAND2 = 8'hF0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // timer control field positions and the global enable bit of the enable register
  localparam int TC_X0_SENSE = 0;
  localparam int TC_X0_PEND = 1;
  localparam int TC_X1_SENSE = 2;
  localparam int TC_X1_PEND = 3;
  localparam int TC_TMR0_OVF = 5;
  localparam int TC_TMR1_OVF = 7;
  localparam int EN_GLOBAL = 7;
  // source indices equal their fixed order
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  // vector = base + 8 * order
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  // long call takes four cycles after the detect cycle
  localparam int CALL_CYCLES = 4;
  typedef enum logic [1:0] {MIH_IDLE, MIH_CALL, MIH_WAIT} mih_state_t;
endpackage

/* logic/mih_irq_handler.sv */
// interrupt handler: pending flags, enables, priority arbitration and vector requests
module mih_irq_handler #(
  parameter int NUM_SRC = mih_pkg::NUM_SRC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  output logic [7:0] reg_rdata_out,
  // external pins, active low
  input wire logic ext_irq0_n_in,
  input wire logic ext_irq1_n_in,
  // peripheral events (bit per source; only bits 1 and 3 used) and pending flags of peripherals
  input wire logic [NUM_SRC-1:0] src_event_in,
  input wire logic [NUM_SRC-1:0] periph_pending_in,
  // cpu sequencer
  input wire logic instr_done_in,
  input wire logic irq_return_done_in,
  output logic call_req_out,
  output logic [15:0] call_vector_out,
  output logic call_busy_out
);
  // the enable and priority maps are wired for exactly this many sources
  if (NUM_SRC != mih_pkg::NUM_SRC) begin : g_bad_src_count
    $error("source count must be 22");
  end

  logic [7:0] tmr_ctrl_r, tmr_ctrl_nxt;
  logic [7:0] irq_en_r, irq_en_nxt, irq_pri_r, irq_pri_nxt;
  logic [7:0] xirq_en1_r, xirq_en1_nxt, xirq_en2_r, xirq_en2_nxt, eip1_r, eip1_nxt, eip2_r, eip2_nxt;
  logic [7:0] accum_r, accum_nxt, operand2_r, operand2_nxt;
  logic ext0_pin_d_r, ext0_pin_d_nxt, ext1_pin_d_r, ext1_pin_d_nxt;
  logic [1:0] active_r, active_nxt;
  logic post_return_r, post_return_nxt;
  mih_pkg::mih_state_t state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [15:0] vec_r, vec_nxt;
  logic [mih_pkg::SRC_W-1:0] src_r, src_nxt;

  logic [NUM_SRC-1:0] pend, en, pri, req;
  logic ext0_fall, ext1_fall, ext0_sense_select, ext1_sense_select;
  logic ext0_pending, ext1_pending, global_irq_enable;
  logic hit_hi, hit_lo, win_ok;
  logic [mih_pkg::SRC_W-1:0] win_hi, win_lo, win;

  assign ext0_sense_select = tmr_ctrl_r[mih_pkg::TC_X0_SENSE];
  assign ext1_sense_select = tmr_ctrl_r[mih_pkg::TC_X1_SENSE];
  assign global_irq_enable = irq_en_r[mih_pkg::EN_GLOBAL];
  // delay flops reset to the idle high level, so reset makes no false edge
  assign ext0_fall = ext0_pin_d_r & ~ext_irq0_n_in;
  assign ext1_fall = ext1_pin_d_r & ~ext_irq1_n_in;
  // level mode reads the pin itself, not a latch
  assign ext0_pending = ext0_sense_select ? tmr_ctrl_r[mih_pkg::TC_X0_PEND] : ~ext_irq0_n_in;
  assign ext1_pending = ext1_sense_select ? tmr_ctrl_r[mih_pkg::TC_X1_PEND] : ~ext_irq1_n_in;

  // pending, enable and priority vectors indexed by fixed order
  always_comb begin
    pend = periph_pending_in;
    pend[mih_pkg::SRC_EXT0] = ext0_pending;
    pend[mih_pkg::SRC_TMR0] = tmr_ctrl_r[mih_pkg::TC_TMR0_OVF];
    pend[mih_pkg::SRC_EXT1] = ext1_pending;
    pend[mih_pkg::SRC_TMR1] = tmr_ctrl_r[mih_pkg::TC_TMR1_OVF];
    en = {xirq_en2_r, xirq_en1_r, irq_en_r[5:0]};
    pri = {eip2_r, eip1_r, irq_pri_r[5:0]};
    req = pend & en & {NUM_SRC{global_irq_enable}};
  end

  // lowest order number wins within each level
  always_comb begin
    hit_hi = 1'b0;
    hit_lo = 1'b0;
    win_hi = '0;
    win_lo = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i] && pri[i]) begin
        hit_hi = 1'b1;
        win_hi = i[mih_pkg::SRC_W-1:0];
      end
      if (req[i] && !pri[i]) begin
        hit_lo = 1'b1;
        win_lo = i[mih_pkg::SRC_W-1:0];
      end
    end
    // high level needs no routine of high level running; low needs none at all
    win = (hit_hi && !active_r[1]) ? win_hi : win_lo;
    win_ok = (hit_hi && !active_r[1]) || (hit_lo && active_r == 2'b00);
    if (post_return_r) win_ok = 1'b0;
  end

  // vectoring sequence
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    vec_nxt = vec_r;
    src_nxt = src_r;
    active_nxt = active_r;
    post_return_nxt = post_return_r;
    if (irq_return_done_in) begin
      // pop the highest active level; the next instruction runs before any new call
      if (active_r[1]) active_nxt[1] = 1'b0;
      else active_nxt[0] = 1'b0;
      post_return_nxt = 1'b1;
    end else if (instr_done_in && post_return_r) begin
      post_return_nxt = 1'b0;
    end
    unique case (state_r)
      mih_pkg::MIH_IDLE: begin
        if (win_ok && instr_done_in && !irq_return_done_in) begin
          state_nxt = mih_pkg::MIH_CALL;
          cnt_nxt = 3'(mih_pkg::CALL_CYCLES - 1);
          src_nxt = win;
          vec_nxt = mih_pkg::VEC_BASE + (16'(win) << mih_pkg::VEC_SHIFT);
          if (pri[win]) active_nxt[1] = 1'b1;
          else active_nxt[0] = 1'b1;
        end
      end
      mih_pkg::MIH_CALL: begin
        if (cnt_r == 3'h0) state_nxt = mih_pkg::MIH_WAIT;
        else cnt_nxt = cnt_r - 3'h1;
      end
      mih_pkg::MIH_WAIT: begin
        state_nxt = mih_pkg::MIH_IDLE;
      end
    endcase
  end
  assign call_req_out = (state_r == mih_pkg::MIH_CALL) && (cnt_r == 3'h0);
  assign call_vector_out = vec_r;
  assign call_busy_out = (state_r != mih_pkg::MIH_IDLE);

  // register file and pending flag updates
  always_comb begin
    tmr_ctrl_nxt = tmr_ctrl_r;
    irq_en_nxt = irq_en_r;
    irq_pri_nxt = irq_pri_r;
    xirq_en1_nxt = xirq_en1_r;
    xirq_en2_nxt = xirq_en2_r;
    eip1_nxt = eip1_r;
    eip2_nxt = eip2_r;
    accum_nxt = accum_r;
    operand2_nxt = operand2_r;
    ext0_pin_d_nxt = ext_irq0_n_in;
    ext1_pin_d_nxt = ext_irq1_n_in;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        mih_pkg::ADDR_TMR_CTRL: tmr_ctrl_nxt = reg_wdata_in;
        mih_pkg::ADDR_IRQ_EN: irq_en_nxt = reg_wdata_in;
        mih_pkg::ADDR_IRQ_PRI: irq_pri_nxt = reg_wdata_in;
        mih_pkg::ADDR_XIRQ_EN1: xirq_en1_nxt = reg_wdata_in;
        mih_pkg::ADDR_XIRQ_EN2: xirq_en2_nxt = reg_wdata_in;
        mih_pkg::ADDR_EIP1: eip1_nxt = reg_wdata_in;
        mih_pkg::ADDR_EIP2: eip2_nxt = reg_wdata_in;
        mih_pkg::ADDR_ACCUM: accum_nxt = reg_wdata_in;
        mih_pkg::ADDR_OPERAND2: operand2_nxt = reg_wdata_in;
        default: ;
      endcase
    end
    // hardware clear on vectoring, then events; set wins over any clear
    if (state_r == mih_pkg::MIH_IDLE && state_nxt == mih_pkg::MIH_CALL) begin
      if (src_nxt == mih_pkg::SRC_TMR0) tmr_ctrl_nxt[mih_pkg::TC_TMR0_OVF] = 1'b0;
      if (src_nxt == mih_pkg::SRC_TMR1) tmr_ctrl_nxt[mih_pkg::TC_TMR1_OVF] = 1'b0;
      if (src_nxt == mih_pkg::SRC_EXT0 && ext0_sense_select) tmr_ctrl_nxt[mih_pkg::TC_X0_PEND] = 1'b0;
      if (src_nxt == mih_pkg::SRC_EXT1 && ext1_sense_select) tmr_ctrl_nxt[mih_pkg::TC_X1_PEND] = 1'b0;
    end
    if (src_event_in[mih_pkg::SRC_TMR0]) tmr_ctrl_nxt[mih_pkg::TC_TMR0_OVF] = 1'b1;
    if (src_event_in[mih_pkg::SRC_TMR1]) tmr_ctrl_nxt[mih_pkg::TC_TMR1_OVF] = 1'b1;
    if (ext0_sense_select && ext0_fall) tmr_ctrl_nxt[mih_pkg::TC_X0_PEND] = 1'b1;
    if (ext1_sense_select && ext1_fall) tmr_ctrl_nxt[mih_pkg::TC_X1_PEND] = 1'b1;
  end

  always_comb begin
    unique case (reg_addr_in)
      mih_pkg::ADDR_TMR_CTRL: reg_rdata_out = {tmr_ctrl_r[7:4], ext1_pending, tmr_ctrl_r[2], ext0_pending, tmr_ctrl_r[0]};
      mih_pkg::ADDR_IRQ_EN: reg_rdata_out = irq_en_r;
      mih_pkg::ADDR_IRQ_PRI: reg_rdata_out = irq_pri_r;
      mih_pkg::ADDR_XIRQ_EN1: reg_rdata_out = xirq_en1_r;
      mih_pkg::ADDR_XIRQ_EN2: reg_rdata_out = xirq_en2_r;
      mih_pkg::ADDR_EIP1: reg_rdata_out = eip1_r;
      mih_pkg::ADDR_EIP2: reg_rdata_out = eip2_r;
      mih_pkg::ADDR_ACCUM: reg_rdata_out = accum_r;
      mih_pkg::ADDR_OPERAND2: reg_rdata_out = operand2_r;
      default: reg_rdata_out = mih_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tmr_ctrl_r <= mih_pkg::RESET_BYTE;
      irq_en_r <= mih_pkg::RESET_BYTE;
      irq_pri_r <= mih_pkg::RESET_BYTE;
      xirq_en1_r <= mih_pkg::RESET_BYTE;
      xirq_en2_r <= mih_pkg::RESET_BYTE;
      eip1_r <= mih_pkg::RESET_BYTE;
      eip2_r <= mih_pkg::RESET_BYTE;
      accum_r <= mih_pkg::RESET_BYTE;
      operand2_r <= mih_pkg::RESET_BYTE;
      ext0_pin_d_r <= 1'b1;
      ext1_pin_d_r <= 1'b1;
      active_r <= 2'b00;
      post_return_r <= 1'b0;
      state_r <= mih_pkg::MIH_IDLE;
      cnt_r <= 3'h0;
      vec_r <= 16'h0000;
      src_r <= '0;
    end else begin
      tmr_ctrl_r <= tmr_ctrl_nxt;
      irq_en_r <= irq_en_nxt;
      irq_pri_r <= irq_pri_nxt;
      xirq_en1_r <= xirq_en1_nxt;
      xirq_en2_r <= xirq_en2_nxt;
      eip1_r <= eip1_nxt;
      eip2_r <= eip2_nxt;
      accum_r <= accum_nxt;
      operand2_r <= operand2_nxt;
      ext0_pin_d_r <= ext0_pin_d_nxt;
      ext1_pin_d_r <= ext1_pin_d_nxt;
      active_r <= active_nxt;
      post_return_r <= post_return_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      vec_r <= vec_nxt;
      src_r <= src_nxt;
    end
  end

  property p_call_after_four;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (state_r == mih_pkg::MIH_IDLE && state_nxt == mih_pkg::MIH_CALL) |-> ##4 call_req_out;
  endproperty
  a_call_after_four: assert property (p_call_after_four) else $error("long call not issued after four cycles");

  property p_no_call_without_ea;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (!global_irq_enable && state_r == mih_pkg::MIH_IDLE) |=> state_r == mih_pkg::MIH_IDLE;
  endproperty
  a_no_call_without_ea: assert property (p_no_call_without_ea) else $error("call started with global enable low");

  property p_vector_formula;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      call_req_out |-> call_vector_out == mih_pkg::VEC_BASE + (16'(src_r) << mih_pkg::VEC_SHIFT);
  endproperty
  a_vector_formula: assert property (p_vector_formula) else $error("vector address mismatch");

  property p_edge_clear;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (state_r == mih_pkg::MIH_IDLE && state_nxt == mih_pkg::MIH_CALL && src_nxt == mih_pkg::SRC_TMR0
       && !src_event_in[mih_pkg::SRC_TMR0]) |=> !tmr_ctrl_r[mih_pkg::TC_TMR0_OVF];
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("timer 0 flag not cleared on vectoring");

  property p_event_sets;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      src_event_in[mih_pkg::SRC_TMR1] |=> tmr_ctrl_r[mih_pkg::TC_TMR1_OVF];
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("timer 1 event lost");

  property p_level_tracks;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      !ext0_sense_select |-> ext0_pending == !ext_irq0_n_in;
  endproperty
  a_level_tracks: assert property (p_level_tracks) else $error("level flag does not follow pin");

  property p_high_not_preempted;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      active_r[1] && !irq_return_done_in |=> !(state_r == mih_pkg::MIH_CALL && $past(state_r) == mih_pkg::MIH_IDLE);
  endproperty
  a_high_not_preempted: assert property (p_high_not_preempted) else $error("high routine preempted");

  property p_post_return_wait;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      irq_return_done_in |=> state_r != mih_pkg::MIH_CALL || $past(state_r) != mih_pkg::MIH_IDLE;
  endproperty
  a_post_return_wait: assert property (p_post_return_wait) else $error("call right after return");
endmodule // mih_irq_handler

/* sim/mih_cpu_model.sv */
// cpu sequencer model: ends instructions and returns on request, records every long call
module mih_cpu_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // call requests from the handler
  input wire logic call_req_in,
  input wire logic [15:0] call_vector_in,
  // sequencer strobes
  output logic instr_done_out,
  output logic irq_return_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_calls;
  logic [15:0] last_vec;
  initial begin
    instr_done_out = 1'b0;
    irq_return_done_out = 1'b0;
    n_calls = 0;
    last_vec = 16'h0000;
  end
  // sampled mid-cycle since the call request is combinational from state
  always @(negedge sys_clk_in) begin
    if (sys_rst_in === 1'b0 && call_req_in === 1'b1) begin
      n_calls++;
      last_vec = call_vector_in;
    end
  end
  // idle cycles model a slow instruction before it completes
  task automatic issue_instr(input int idle);
    repeat (idle) @(negedge sys_clk_in);
    @(negedge sys_clk_in);
    instr_done_out = 1'b1;
    @(negedge sys_clk_in);
    instr_done_out = 1'b0;
  endtask
  task automatic finish_return();
    @(negedge sys_clk_in);
    irq_return_done_out = 1'b1;
    @(negedge sys_clk_in);
    irq_return_done_out = 1'b0;
  endtask
endmodule // mih_cpu_model

/* sim/tb.sv */
// testbench: register access, source vectoring, priority and external pin sensing
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, x0_n, x1_n, idone, rdone, creq, busy, ea;
  logic [7:0] addr, wdata, rdata;
  logic [21:0] ev, pend, en, pri;
  logic [15:0] cvec;
  int n_fail, num_checks;
  mih_irq_handler dut_u (.sys_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rdata_out(rdata), .ext_irq0_n_in(x0_n), .ext_irq1_n_in(x1_n), .src_event_in(ev),
    .periph_pending_in(pend), .instr_done_in(idone), .irq_return_done_in(rdone), .call_req_out(creq),
    .call_vector_out(cvec), .call_busy_out(busy));
  mih_cpu_model cpu_u (.sys_clk_in(clk), .sys_rst_in(rst), .call_req_in(creq), .call_vector_in(cvec),
    .instr_done_out(idone), .irq_return_done_out(rdone));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    #1 check({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic put_en();
    wr_reg(mih_pkg::ADDR_IRQ_EN, {ea, 1'b0, en[5:0]});
    wr_reg(mih_pkg::ADDR_XIRQ_EN1, en[13:6]);
    wr_reg(mih_pkg::ADDR_XIRQ_EN2, en[21:14]);
    wr_reg(mih_pkg::ADDR_IRQ_PRI, {2'b00, pri[5:0]});
    wr_reg(mih_pkg::ADDR_EIP1, pri[13:6]);
    wr_reg(mih_pkg::ADDR_EIP2, pri[21:14]);
  endtask
  // one instruction ends; a call is expected or not, and busy must be gone afterwards
  task automatic run(input logic want, input logic [15:0] vec, input int idle);
    int c0;
    c0 = cpu_u.n_calls;
    cpu_u.issue_instr(idle);
    repeat (7) @(negedge clk);
    check(16'(cpu_u.n_calls - c0), {15'h0000, want});
    if (want) check(cpu_u.last_vec, vec);
    check({15'h0000, busy}, 16'h0000);
  endtask
  // return plus the one instruction that must run before any new call
  task automatic leave();
    cpu_u.finish_return();
    run(1'b0, 16'h0000, 0);
  endtask
  task automatic tick(input int s);
    @(negedge clk);
    ev[s] = 1'b1;
    @(negedge clk);
    ev[s] = 1'b0;
  endtask
  initial begin
    rst = 1'b1;
    {wr, idone, rdone} = 3'b000;
    {x0_n, x1_n, ea} = 3'b110;
    {addr, wdata} = 16'h0000;
    {ev, pend, en, pri} = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd_chk(mih_pkg::ADDR_ACCUM, 8'h00);
    rd_chk(mih_pkg::ADDR_OPERAND2, 8'h00);
    rd_chk(mih_pkg::ADDR_TMR_CTRL, 8'h00);
    rd_chk(mih_pkg::ADDR_IRQ_EN, 8'h00);
    rd_chk(mih_pkg::ADDR_XIRQ_EN2, 8'h00);
    rd_chk(8'h01, 8'h00);
    wr_reg(mih_pkg::ADDR_ACCUM, 8'hA5);
    wr_reg(mih_pkg::ADDR_OPERAND2, 8'h5A);
    rd_chk(mih_pkg::ADDR_ACCUM, 8'hA5);
    rd_chk(mih_pkg::ADDR_OPERAND2, 8'h5A);
    tick(mih_pkg::SRC_TMR0);
    rd_chk(mih_pkg::ADDR_TMR_CTRL, 8'h20);
    run(1'b0, 16'h0000, 0);
    en[1] = 1'b1;
    put_en();
    run(1'b0, 16'h0000, 0);
    ea = 1'b1;
    put_en();
    run(1'b1, 16'h000B, 3);
    rd_chk(mih_pkg::ADDR_TMR_CTRL, 8'h00);
    leave();
    wr_reg(mih_pkg::ADDR_TMR_CTRL, 8'h20);
    run(1'b1, 16'h000B, 0);
    leave();
    en = 22'h000008;
    put_en();
    tick(mih_pkg::SRC_TMR1);
    run(1'b1, 16'h001B, 0);
    rd_chk(mih_pkg::ADDR_TMR_CTRL, 8'h00);
    leave();
    for (int s = 4; s < 22; s++) begin
      en = '0;
      en[s] = 1'b1;
      put_en();
      pend[s] = 1'b1;
      run(1'b1, mih_pkg::VEC_BASE + 16'(s << 3), 0);
      cpu_u.finish_return();
      run(1'b0, 16'h0000, 0);
      run(1'b1, mih_pkg::VEC_BASE + 16'(s << 3), 0);
      pend[s] = 1'b0;
      leave();
    end
    en = 22'h000130;
    ea = 1'b0;
    put_en();
    pend[4] = 1'b1;
    pend[8] = 1'b1;
    run(1'b0, 16'h0000, 0);
    ea = 1'b1;
    put_en();
    run(1'b1, 16'h0023, 0);
    pri[8] = 1'b1;
    put_en();
    run(1'b1, 16'h0043, 0);
    pri[5] = 1'b1;
    put_en();
    pend[5] = 1'b1;
    run(1'b0, 16'h0000, 0);
    pend = '0;
    leave();
    leave();
    en = '0;
    pri = '0;
    put_en();
    en[0] = 1'b1;
    en[2] = 1'b1;
    wr_reg(mih_pkg::ADDR_TMR_CTRL, 8'h01);
    @(negedge clk) x0_n = 1'b0;
    repeat (3) @(negedge clk);
    x0_n = 1'b1;
    rd_chk(mih_pkg::ADDR_TMR_CTRL, 8'h03);
    put_en();
    run(1'b1, 16'h0003, 0);
    rd_chk(mih_pkg::ADDR_TMR_CTRL, 8'h01);
    leave();
    wr_reg(mih_pkg::ADDR_TMR_CTRL, 8'h00);
    @(negedge clk) x1_n = 1'b0;
    repeat (3) @(negedge clk);
    rd_chk(mih_pkg::ADDR_TMR_CTRL, 8'h08);
    run(1'b1, 16'h0013, 0);
    x1_n = 1'b1;
    repeat (3) @(negedge clk);
    rd_chk(mih_pkg::ADDR_TMR_CTRL, 8'h00);
    leave();
    test_done();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule // tb
